// ### rtl/tcc_unit.v
/*
  Timer input capture and output compare unit: three capture channels,
  four compare channels, one shared capture-four/compare-five channel.
  Assumes the free-running count and its increment phase come from the
  counter block on core_clk; capture pins are asynchronous.
*/
`default_nettype none
`include "tcc_consts.vh"
module tcc_unit #(
  parameter CW = 16
) (
  input wire core_clk,
  input wire srst,
  input wire clk_en,
  input wire count_phase,
  input wire [CW-1:0] free_running_count,
  input wire [3:0] capture_pin,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output reg [4:0] compare_pin_out,
  output reg [4:0] compare_pin_drive,
  output wire irq
);
  reg [3:0] sync1_r;
  reg [3:0] sync2_r;
  reg [3:0] prev_r;
  reg [CW-1:0] cap_r [0:2];
  reg [CW-1:0] cmp_r [0:3];
  reg [CW-1:0] shr_r;
  reg [7:0] edge_ctl_r;
  reg [7:0] pin_ctl_r;
  reg [7:0] mask1_r;
  reg [7:0] flag1_r;
  reg [7:0] pin_mask1_r;
  reg [7:0] pin_data1_r;
  reg [7:0] accum_ctl_r;
  reg [3:0] pend_r;
  reg [3:0] blk_r;
  reg [4:0] match_r;
  reg [3:0] hit;
  reg [3:0] blk_nxt;
  reg [4:0] match;
  reg [4:0] pin_nxt;
  reg [7:0] flag_set;
  integer i;

  function edge_hit;
    input [1:0] sel;
    input now;
    input was;
    begin
      case (sel)
        2'b01: edge_hit = now & ~was;
        2'b10: edge_hit = ~now & was;
        2'b11: edge_hit = now ^ was;
        default: edge_hit = 1'b0;
      endcase
    end
  endfunction

  function act;
    input [1:0] ml;
    input cur;
    begin
      case (ml)
        2'b01: act = ~cur;
        2'b10: act = 1'b0;
        2'b11: act = 1'b1;
        default: act = cur;
      endcase
    end
  endfunction

  wire shr_cap = accum_ctl_r[`TCC_SHR_SEL_BIT];
  // per-pin action pair; pin0 is compare five, pin4 has none
  wire [9:0] pin_pair = {2'b00, pin_ctl_r[3:2], pin_ctl_r[5:4], pin_ctl_r[7:6],
    pin_ctl_r[1:0] & {2{~shr_cap}}};
  wire [4:0] pin_match = {1'b0, match_r[3:1], match_r[4]};
  wire wr_flag = reg_wr && (reg_addr == `TCC_A_FLAG1);

  always @* begin
    for (i = 0; i < 4; i = i + 1) begin
      hit[i] = edge_hit(edge_ctl_r[7-2*i -: 2], sync2_r[i], prev_r[i]);
    end
    hit[3] = hit[3] & shr_cap;
    blk_nxt = 4'b0000;
    if (reg_rd) begin
      blk_nxt[0] = (reg_addr == `TCC_A_CAP1_HI);
      blk_nxt[1] = (reg_addr == `TCC_A_CAP2_HI);
      blk_nxt[2] = (reg_addr == `TCC_A_CAP3_HI);
      blk_nxt[3] = (reg_addr == `TCC_A_SHR_HI) && shr_cap;
    end
    for (i = 0; i < 4; i = i + 1) begin
      match[i] = (cmp_r[i] == free_running_count);
    end
    match[4] = ~shr_cap && (shr_r == free_running_count);
    flag_set = `TCC_ZERO8;
    flag_set[2:0] = {hit[0], hit[1], hit[2]};
    flag_set[`TCC_FLG_SHARED] = hit[3];
    if (count_phase) begin
      flag_set[7:4] = {match[0], match[1], match[2], match[3]};
      flag_set[`TCC_FLG_SHARED] = hit[3] | match[4];
    end
    pin_nxt = compare_pin_out;
    for (i = 0; i < 5; i = i + 1) begin
      if (pin_match[i]) begin
        pin_nxt[i] = act(pin_pair[2*i+1 -: 2], compare_pin_out[i]);
      end
    end
    if (match_r[0]) begin
      for (i = 0; i < 5; i = i + 1) begin
        if (pin_mask1_r[`TCC_PIN_LSB+i]) begin
          pin_nxt[i] = pin_data1_r[`TCC_PIN_LSB+i];
        end
      end
    end
  end

  assign irq = |(flag1_r & mask1_r);

  always @(posedge core_clk) begin
    if (srst) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      prev_r <= 4'h0;
      edge_ctl_r <= `TCC_ZERO8;
      pin_ctl_r <= `TCC_ZERO8;
      mask1_r <= `TCC_ZERO8;
      flag1_r <= `TCC_ZERO8;
      pin_mask1_r <= `TCC_ZERO8;
      pin_data1_r <= `TCC_ZERO8;
      accum_ctl_r <= `TCC_ZERO8;
      pend_r <= 4'h0;
      blk_r <= 4'h0;
      match_r <= 5'h00;
      compare_pin_out <= 5'h00;
      compare_pin_drive <= 5'h1F;
      reg_rdata <= `TCC_ZERO8;
      for (i = 0; i < 4; i = i + 1) begin
        cmp_r[i] <= `TCC_CMP_RST;
      end
    end else if (clk_en) begin
      sync1_r <= capture_pin;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
      blk_r <= blk_nxt;
      // pin change two cycles after match
      match_r <= count_phase ? match : 5'h00;
      compare_pin_out <= pin_nxt;
      // Drive enable low where action or mask connects pin
      for (i = 0; i < 5; i = i + 1) begin
        compare_pin_drive[i] <= ~(pin_mask1_r[`TCC_PIN_LSB+i] |
          (|pin_pair[2*i+1 -: 2]));
      end
      for (i = 0; i < 4; i = i + 1) begin
        if ((hit[i] | pend_r[i]) && !blk_r[i] && !count_phase) begin
          pend_r[i] <= 1'b0;
          if (i < 3) begin
            cap_r[i] <= free_running_count;
          end else begin
            shr_r <= free_running_count;
          end
        end else if (hit[i]) begin
          pend_r[i] <= 1'b1;
        end
      end
      flag1_r <= (wr_flag ? (flag1_r & ~reg_wdata) : flag1_r) | flag_set;
      if (reg_wr) begin
        case (reg_addr)
          `TCC_A_CMP1_HI: cmp_r[0][15:8] <= reg_wdata;
          `TCC_A_CMP1_LO: cmp_r[0][7:0] <= reg_wdata;
          `TCC_A_CMP2_HI: cmp_r[1][15:8] <= reg_wdata;
          `TCC_A_CMP2_LO: cmp_r[1][7:0] <= reg_wdata;
          `TCC_A_CMP3_HI: cmp_r[2][15:8] <= reg_wdata;
          `TCC_A_CMP3_LO: cmp_r[2][7:0] <= reg_wdata;
          `TCC_A_CMP4_HI: cmp_r[3][15:8] <= reg_wdata;
          `TCC_A_CMP4_LO: cmp_r[3][7:0] <= reg_wdata;
          `TCC_A_SHR_HI: if (!shr_cap) shr_r[15:8] <= reg_wdata;
          `TCC_A_SHR_LO: if (!shr_cap) shr_r[7:0] <= reg_wdata;
          `TCC_A_PINCTL: pin_ctl_r <= reg_wdata;
          `TCC_A_EDGCTL: edge_ctl_r <= reg_wdata;
          `TCC_A_MASK1: mask1_r <= reg_wdata;
          `TCC_A_PMASK1: pin_mask1_r <= reg_wdata;
          `TCC_A_PDATA1: pin_data1_r <= reg_wdata;
          `TCC_A_ACCCTL: accum_ctl_r <= reg_wdata;
          default: ;
        endcase
      end
      reg_rdata <= `TCC_ZERO8;
      if (reg_rd) begin
        case (reg_addr)
          `TCC_A_CAP1_HI: reg_rdata <= cap_r[0][15:8];
          `TCC_A_CAP1_LO: reg_rdata <= cap_r[0][7:0];
          `TCC_A_CAP2_HI: reg_rdata <= cap_r[1][15:8];
          `TCC_A_CAP2_LO: reg_rdata <= cap_r[1][7:0];
          `TCC_A_CAP3_HI: reg_rdata <= cap_r[2][15:8];
          `TCC_A_CAP3_LO: reg_rdata <= cap_r[2][7:0];
          `TCC_A_CMP1_HI: reg_rdata <= cmp_r[0][15:8];
          `TCC_A_CMP1_LO: reg_rdata <= cmp_r[0][7:0];
          `TCC_A_CMP2_HI: reg_rdata <= cmp_r[1][15:8];
          `TCC_A_CMP2_LO: reg_rdata <= cmp_r[1][7:0];
          `TCC_A_CMP3_HI: reg_rdata <= cmp_r[2][15:8];
          `TCC_A_CMP3_LO: reg_rdata <= cmp_r[2][7:0];
          `TCC_A_CMP4_HI: reg_rdata <= cmp_r[3][15:8];
          `TCC_A_CMP4_LO: reg_rdata <= cmp_r[3][7:0];
          `TCC_A_SHR_HI: reg_rdata <= shr_r[15:8];
          `TCC_A_SHR_LO: reg_rdata <= shr_r[7:0];
          `TCC_A_PINCTL: reg_rdata <= pin_ctl_r;
          `TCC_A_EDGCTL: reg_rdata <= edge_ctl_r;
          `TCC_A_MASK1: reg_rdata <= mask1_r;
          `TCC_A_FLAG1: reg_rdata <= flag1_r;
          `TCC_A_PMASK1: reg_rdata <= pin_mask1_r;
          `TCC_A_PDATA1: reg_rdata <= pin_data1_r;
          `TCC_A_ACCCTL: reg_rdata <= accum_ctl_r;
          default: reg_rdata <= `TCC_ZERO8;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ### rtl/tcc_consts.vh
/*
  Constants for the timer capture/compare unit: register indices, field
  positions and reset values. Assumes inclusion by bare name.
*/
`ifndef TCC_CONSTS_VH
`define TCC_CONSTS_VH
// Register byte addresses (8-bit register port)
`define TCC_A_CAP1_HI 8'h10
`define TCC_A_CAP1_LO 8'h11
`define TCC_A_CAP2_HI 8'h12
`define TCC_A_CAP2_LO 8'h13
`define TCC_A_CAP3_HI 8'h14
`define TCC_A_CAP3_LO 8'h15
`define TCC_A_CMP1_HI 8'h16
`define TCC_A_CMP1_LO 8'h17
`define TCC_A_CMP2_HI 8'h18
`define TCC_A_CMP2_LO 8'h19
`define TCC_A_CMP3_HI 8'h1A
`define TCC_A_CMP3_LO 8'h1B
`define TCC_A_CMP4_HI 8'h1C
`define TCC_A_CMP4_LO 8'h1D
`define TCC_A_SHR_HI 8'h1E
`define TCC_A_SHR_LO 8'h1F
`define TCC_A_PINCTL 8'h20
`define TCC_A_EDGCTL 8'h21
`define TCC_A_MASK1 8'h22
`define TCC_A_FLAG1 8'h23
`define TCC_A_PMASK1 8'h0C
`define TCC_A_PDATA1 8'h0D
`define TCC_A_ACCCTL 8'h26
// Field positions
`define TCC_SHR_SEL_BIT 2
`define TCC_FLG_SHARED 3
`define TCC_FLG_CMP1 7
`define TCC_PIN_LSB 3
// Reset values
`define TCC_CMP_RST 16'hFFFF
`define TCC_ZERO8 8'h00
`define TCC_ZERO16 16'h0000
`endif

// ### test/tcc_count_model.sv
/* Free-running counter model for the far side of tcc_unit.
   Assumes one clock; run low freezes the count, phase keeps toggling. */
`default_nettype none
module tcc_count_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic run,
  output logic [15:0] count,
  output logic phase
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge clk) begin
    if (srst) begin
      count <= 16'h0000;
      phase <= 1'b0;
    end else begin
      phase <= ~phase;
      if (phase && run)
        count <= count + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ### test/tcc_unit_properties.sv
/* Port checker for tcc_unit.
   Assumes binding to tcc_unit with clk_en held high. */
`default_nettype none
`include "tcc_consts.vh"
module tcc_unit_properties #(
  parameter CW = 16
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic count_phase,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [4:0] compare_pin_out,
  input wire logic [4:0] compare_pin_drive,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence mask_off;
    reg_wr && reg_addr == `TCC_A_MASK1 && reg_wdata == 8'h00;
  endsequence
  sequence no_wr4;
    !reg_wr [*4];
  endsequence
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");
  unmapped_read_a: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  reset_irq_quiet_a: assert property ($fell(srst) ##0 no_wr4 |-> !irq)
    else $error("irq after reset");
  reset_pins_idle_a: assert property ($fell(srst) |-> compare_pin_drive == 5'h1f)
    else $error("pins driven after reset");
  irq_fall_cause_a: assert property ($fell(irq) |-> $past(reg_wr) &&
    ($past(reg_addr) == `TCC_A_FLAG1 || $past(reg_addr) == `TCC_A_MASK1 ||
    $past(reg_addr) == `TCC_A_ACCCTL))
    else $error("irq fell without write");
  pin_change_phase_a: assert property ($changed(compare_pin_out) |-> $past(count_phase, 2))
    else $error("pin moved off compare phase");
  drive_after_write_a: assert property ($changed(compare_pin_drive) |->
    $past(reg_wr) || $past(reg_wr, 2))
    else $error("drive moved without write");
  irq_mask_off_a: assert property (mask_off ##1 no_wr4 |-> !irq)
    else $error("irq with masks clear");
endmodule
`default_nettype wire

// ### test/tcc_unit_test.sv
/* Self-checking bench for tcc_unit.
   Assumes tcc_count_model as counter block and a 40 MHz core_clk. */
`default_nettype none
`include "tcc_consts.vh"
module tcc_unit_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, run = 1, ph, irq;
  logic [3:0] pin = 4'h0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, i;
  logic [15:0] frc, t;
  logic [4:0] pout, pdrv;
  logic [1:0] md [3] = '{2'b01, 2'b10, 2'b11};
  logic [2:0] ex = 3'b101;
  int num_errors = 0, n_compared = 0;
  tcc_count_model tcc_count_model_inst (.clk(core_clk), .srst(srst), .run(run),
    .count(frc), .phase(ph));
  tcc_unit tcc_unit_inst (.core_clk(core_clk), .srst(srst), .clk_en(1'b1), .count_phase(ph),
    .free_running_count(frc), .capture_pin(pin), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .compare_pin_out(pout),
    .compare_pin_drive(pdrv), .irq(irq));
  initial forever #12.5 core_clk = ~core_clk;
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    reg_wr <= 1'b1;
    cyc(1);
    reg_wr <= 1'b0;
    cyc(1);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    addr <= a;
    reg_rd <= 1'b1;
    cyc(1);
    reg_rd <= 1'b0;
    #1 chk("register read", e, {8'h00, rdata});
    cyc(1);
  endtask
  task automatic edge_to(input logic [3:0] v);
    pin <= v;
    cyc(8);
  endtask
  task automatic give_verdict;
    if (num_errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #500000 num_errors++;
    give_verdict;
  end
  initial begin
    cyc(6);
    srst <= 1'b0;
    cyc(1);
    wr(`TCC_A_SHR_HI, 8'hff);
    wr(`TCC_A_SHR_LO, 8'hff);
    for (i = 0; i < 8; i++) rdc(`TCC_A_CMP1_HI + i, 16'h00ff);
    rdc(`TCC_A_EDGCTL, 16'h0000);
    rdc(8'h00, 16'h0000);
    for (i = 0; i < 4; i++) begin
      wr(`TCC_A_EDGCTL, {i[1:0], 6'h00});
      wr(`TCC_A_FLAG1, 8'hff);
      edge_to(4'h1);
      rdc(`TCC_A_FLAG1, {13'h0000, i[0], 2'h0});
      wr(`TCC_A_FLAG1, 8'h00);
      rdc(`TCC_A_FLAG1, {13'h0000, i[0], 2'h0});
      wr(`TCC_A_FLAG1, 8'hff);
      edge_to(4'h0);
      rdc(`TCC_A_FLAG1, {13'h0000, i[1], 2'h0});
    end
    run <= 1'b0;
    cyc(4);
    #1 t = frc;
    wr(`TCC_A_EDGCTL, 8'hfc);
    edge_to(4'h7);
    for (i = 0; i < 6; i++) rdc(`TCC_A_CAP1_HI + i, {8'h00, i[0] ? t[7:0] : t[15:8]});
    wr(`TCC_A_FLAG1, 8'hff);
    wr(`TCC_A_EDGCTL, 8'h03);
    edge_to(4'h8);
    rdc(`TCC_A_FLAG1, 16'h0000);
    wr(`TCC_A_ACCCTL, 8'h04);
    edge_to(4'h0);
    rdc(`TCC_A_FLAG1, 16'h0008);
    rdc(`TCC_A_SHR_HI, {8'h00, t[15:8]});
    rdc(`TCC_A_SHR_LO, {8'h00, t[7:0]});
    wr(`TCC_A_MASK1, 8'h08);
    chk("irq", 16'h0001, {15'h0000, irq});
    run <= 1'b1;
    wr(`TCC_A_MASK1, 8'h40);
    for (i = 0; i < 3; i++) begin
      wr(`TCC_A_PINCTL, {md[i], 6'h00});
      #1 t = frc + 16'h0010;
      wr(`TCC_A_CMP2_HI, t[15:8]);
      wr(`TCC_A_CMP2_LO, t[7:0]);
      cyc(48);
      chk("compare pins", {11'h000, ex[i], 1'b0}, {11'h000, pout[4:2], pout[1:0] & 2'b10});
      chk("compare drive", 16'h0000, {15'h0000, pdrv[1]});
    end
    chk("irq", 16'h0001, {15'h0000, irq});
    wr(`TCC_A_FLAG1, 8'h40);
    chk("irq", 16'h0000, {15'h0000, irq});
    wr(`TCC_A_PMASK1, 8'hf8);
    wr(`TCC_A_PDATA1, 8'ha8);
    #1 t = frc + 16'h0010;
    wr(`TCC_A_CMP1_HI, t[15:8]);
    wr(`TCC_A_CMP1_LO, t[7:0]);
    cyc(48);
    chk("mask pins", 16'h0015, {11'h000, pout});
    chk("mask drive", 16'h0000, {11'h000, pdrv});
    wr(`TCC_A_MASK1, 8'h00);
    chk("irq", 16'h0000, {15'h0000, irq});
    give_verdict;
  end
endmodule
bind tcc_unit tcc_unit_properties #(.CW(CW)) tcc_unit_properties_inst (.core_clk(core_clk),
  .srst(srst), .count_phase(count_phase), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .compare_pin_out(compare_pin_out),
  .compare_pin_drive(compare_pin_drive), .irq(irq));
`default_nettype wire
